//--- core/rfac_pkg.sv
// Package: register map, field layout, reset values and carrier types of the rotation block
package rfac_pkg;

  // Register indexes; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_EFFECTS = 8'h71;
  localparam logic [7:0] IDX_START_LO = 8'h74;
  localparam logic [7:0] IDX_START_MID = 8'h75;
  localparam logic [7:0] IDX_START_HI = 8'h76;
  localparam logic [7:0] IDX_PITCH_LO = 8'h78;
  localparam logic [7:0] IDX_PITCH_HI = 8'h79;
  localparam logic [7:0] IDX_FETCH_CTRL = 8'h60;
  localparam logic [7:0] IDX_FETCH_WORDS = 8'h61;
  localparam logic [7:0] IDX_FETCH_LINES = 8'h62;
  localparam logic [7:0] IDX_FETCH_STATUS = 8'h63;
  localparam logic [7:0] IDX_FETCH_ADDR = 8'h64;

  // Bus geometry
  localparam int ADR_W = 10;
  localparam int ADR_IDX_LSB = 2;
  localparam int ADR_IDX_MSB = 9;

  // Field layout
  localparam int ROT_LSB = 0;
  localparam int ROT_MSB = 1;
  localparam int START_W = 17;
  localparam int PITCH_W = 10;
  localparam int CNT_W = 10;
  localparam int START_HI_BIT = 16;
  localparam int PITCH_HI_MSB = 9;
  localparam int CTRL_GO_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;

  // Reset values
  localparam logic [7:0] EFFECTS_RST = 8'h00;
  localparam logic [START_W-1:0] START_RST = 17'h00000;
  localparam logic [PITCH_W-1:0] PITCH_RST = 10'h000;
  localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
  localparam logic [31:0] RDATA_ZERO = 32'h00000000;

  // Rotation select codes
  typedef enum logic [1:0] {
    ROT_0 = 2'b00,
    ROT_90 = 2'b01,
    ROT_180 = 2'b10,
    ROT_270 = 2'b11
  } rfac_rot_type;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rfac_wb_req_type;

  // Wishbone answer to the master
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } rfac_wb_rsp_type;

  // Live configuration seen by the display pipeline
  typedef struct packed {
    rfac_rot_type rot;
    logic [START_W-1:0] start;
    logic [PITCH_W-1:0] pitch;
    logic [7:0] effects;
  } rfac_cfg_type;

  // One dword fetch request toward display memory
  typedef struct packed {
    logic valid;
    logic [START_W-1:0] addr;
    logic lineEnd;
    logic frameEnd;
  } rfac_fetch_type;

endpackage

//--- core/rfac_fetch_gen.sv
// Dword fetch address walker that follows the selected rotation
`timescale 1ns/1ps
module rfac_fetch_gen (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic goPulse,
  input wire rfac_pkg::rfac_cfg_type cfg,
  input wire logic [rfac_pkg::CNT_W-1:0] wordsPerLine,
  input wire logic [rfac_pkg::CNT_W-1:0] lineCount,
  input wire logic fetchReady,
  output rfac_pkg::rfac_fetch_type fetch,
  output logic busy
);
  import rfac_pkg::*;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } rfac_fstate_type;

  // Signed dword step, wrapped modulo the buffer address space
  function automatic logic [START_W-1:0] stepAddr(
    input logic [START_W-1:0] base,
    input logic [START_W-1:0] mag,
    input logic neg
  );
    stepAddr = neg ? base - mag : base + mag;
  endfunction

  rfac_fstate_type state_ff; // Walker state
  logic [START_W-1:0] lineBase_ff; // First dword of current line
  logic [START_W-1:0] pitchX_ff; // Pitch latched at frame start
  rfac_rot_type rot_ff; // Rotation latched at frame start
  logic [CNT_W-1:0] words_ff; // Words per line latched
  logic [CNT_W-1:0] lines_ff; // Lines per frame latched
  logic [CNT_W-1:0] wordCnt_ff; // Word index inside line
  logic [CNT_W-1:0] lineCnt_ff; // Line index inside frame
  logic [START_W-1:0] wordMag; // Step size along a line
  logic [START_W-1:0] lineMag; // Step size between lines
  logic wordNeg; // Along-line step goes down
  logic lineNeg; // Between-line step goes down
  logic take; // Current fetch accepted
  logic lastWord; // Current word ends its line
  logic lastLine; // Current line ends the frame

  // Step directions per rotation; all in dwords so any colour depth works
  always_comb begin
    wordMag = START_W'(1);
    lineMag = pitchX_ff;
    wordNeg = 1'b0;
    lineNeg = 1'b0;
    unique case (rot_ff)
      ROT_0: begin
        wordMag = START_W'(1);
        lineMag = pitchX_ff;
      end
      ROT_90: begin
        wordMag = pitchX_ff;
        lineMag = START_W'(1);
        lineNeg = 1'b1;
      end
      ROT_180: begin
        wordMag = START_W'(1);
        lineMag = pitchX_ff;
        wordNeg = 1'b1;
        lineNeg = 1'b1;
      end
      ROT_270: begin
        wordMag = pitchX_ff;
        lineMag = START_W'(1);
        wordNeg = 1'b1;
      end
    endcase
  end

  assign take = fetch.valid & fetchReady;
  assign lastWord = (wordCnt_ff == words_ff - CNT_W'(1));
  assign lastLine = (lineCnt_ff == lines_ff - CNT_W'(1));
  assign busy = (state_ff == ST_RUN);

  // Frame walk; settings are latched so register writes mid-frame cannot tear it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      lineBase_ff <= START_RST;
      pitchX_ff <= START_RST;
      rot_ff <= ROT_0;
      words_ff <= CNT_RST;
      lines_ff <= CNT_RST;
      wordCnt_ff <= CNT_RST;
      lineCnt_ff <= CNT_RST;
      fetch <= '0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          // A zero-sized frame is ignored
          if (goPulse && wordsPerLine != CNT_RST && lineCount != CNT_RST) begin
            state_ff <= ST_RUN;
            rot_ff <= cfg.rot;
            pitchX_ff <= START_W'(cfg.pitch);
            words_ff <= wordsPerLine;
            lines_ff <= lineCount;
            lineBase_ff <= cfg.start;
            wordCnt_ff <= CNT_RST;
            lineCnt_ff <= CNT_RST;
            fetch.valid <= 1'b1;
            fetch.addr <= cfg.start;
            fetch.lineEnd <= (wordsPerLine == CNT_W'(1));
            fetch.frameEnd <= (wordsPerLine == CNT_W'(1)) && (lineCount == CNT_W'(1));
          end
        end
        ST_RUN: begin
          if (take) begin
            if (lastWord && lastLine) begin
              // Frame done
              state_ff <= ST_IDLE;
              fetch <= '0;
            end else if (lastWord) begin
              // Next line starts one line step from the previous line start
              lineBase_ff <= stepAddr(lineBase_ff, lineMag, lineNeg);
              fetch.addr <= stepAddr(lineBase_ff, lineMag, lineNeg);
              wordCnt_ff <= CNT_RST;
              lineCnt_ff <= lineCnt_ff + CNT_W'(1);
              fetch.lineEnd <= (words_ff == CNT_W'(1));
              fetch.frameEnd <= (words_ff == CNT_W'(1)) &&
                                (lineCnt_ff + CNT_W'(2) == lines_ff);
            end else begin
              // Next dword along the line
              fetch.addr <= stepAddr(fetch.addr, wordMag, wordNeg);
              wordCnt_ff <= wordCnt_ff + CNT_W'(1);
              fetch.lineEnd <= (wordCnt_ff + CNT_W'(2) == words_ff);
              fetch.frameEnd <= (wordCnt_ff + CNT_W'(2) == words_ff) && lastLine;
            end
          end
        end
      endcase
    end
  end

endmodule // rfac_fetch_gen

//--- core/rfac_top.sv
// Rotation configuration registers with Wishbone slave and frame fetch walker
// Summary of operation
// - Two-bit select gives 0, 90, 180, 270
// - Start dword address 17 bits, three bytes
// - Start value zero is first buffer dword
// - Line pitch 10 bits over two bytes
// - Rotation works at every colour depth
`timescale 1ns/1ps
module rfac_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire rfac_pkg::rfac_wb_req_type wbReq,
  output rfac_pkg::rfac_wb_rsp_type wbRsp,
  output rfac_pkg::rfac_cfg_type cfgOut,
  input wire logic fetchReady,
  output rfac_pkg::rfac_fetch_type fetchOut
);
  import rfac_pkg::*;

  // Bus timing: a request is taken on the edge where cyc and stb stand with ack low;
  // the store happens on that edge and ack follows one cycle later, for one cycle only.
  // Registering ack costs a cycle per access but keeps the read mux off the return path.
  // Configuration leaves through one register stage, so the walker and the display side
  // see an effects, start or pitch byte write one edge after the register itself has changed; the counts reach the walker directly.

  // Stored registers
  logic [7:0] effects_ff; // Swap, sub-window and rotation bits
  logic [START_W-1:0] start_ff; // Main window start dword
  logic [PITCH_W-1:0] pitch_ff; // Main window dwords per line
  logic [CNT_W-1:0] words_ff; // Fetch words per display line
  logic [CNT_W-1:0] lines_ff; // Fetch display lines per frame
  logic go_ff; // One-cycle frame start pulse
  logic busy; // Walker running
  logic [7:0] idx; // Register index from the byte address
  logic wrStb; // Write accepted this cycle
  logic rdStb; // Read accepted this cycle
  logic [31:0] nxt_rdData; // Read mux result

  // Word index from a byte address; the two low address bits are ignored
  // Byte offsets 1 to 3 of a word therefore reach the same register
  assign idx = wbReq.adr[ADR_IDX_MSB:ADR_IDX_LSB];
  // Each access is taken once, in the cycle before ack rises
  // Strobes are combinational from the bus and the registered ack
  assign wrStb = wbReq.cyc & wbReq.stb & wbReq.we & ~wbRsp.ack;
  assign rdStb = wbReq.cyc & wbReq.stb & ~wbReq.we & ~wbRsp.ack;

  // Lane 0 write to one register index; shared by the effects register and the go bit
  function automatic logic wrLane0(
    input logic taken,
    input logic [7:0] at,
    input logic [7:0] want,
    input logic lane0
  );
    wrLane0 = taken && (at == want) && lane0;
  endfunction

  // Effects control: all eight bits stored, rotation steers the walker
  // Swap and sub-window bits are kept for readback and passed on in cfgOut.effects; nothing here acts on them
  // A rotation change takes hold at the next frame start, never inside a running frame
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // Rotation returns to none
      effects_ff <= EFFECTS_RST;
    end else if (wrLane0(wrStb, idx, IDX_EFFECTS, wbReq.sel[0])) begin
      // Whole byte stored in one write
      effects_ff <= wbReq.dat[7:0];
    end
  end

  // Start dword address, written byte by byte; only bit 16 lives in the top byte
  // No shadow copy: a frame started between two byte writes sees a mixed address,
  // so software writes all three bytes before it asks for a frame
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // First dword of the buffer
      start_ff <= START_RST;
    end else if (wrStb && wbReq.sel[0]) begin
      unique case (idx)
        IDX_START_LO: begin
          start_ff[7:0] <= wbReq.dat[7:0];
        end
        IDX_START_MID: begin
          start_ff[15:8] <= wbReq.dat[7:0];
        end
        IDX_START_HI: begin
          // Bits 7 to 1 of this byte are not stored and read as zero
          start_ff[START_HI_BIT] <= wbReq.dat[0];
        end
        default: begin
          // Other indexes leave the address alone
          start_ff <= start_ff;
        end
      endcase
    end
  end

  // Line pitch in dwords; top byte keeps two bits
  // The walker steps lines by this count, so a padded virtual line is just a larger value
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // Zero pitch: at 0 and 180 degrees every line restarts at the same dword
      pitch_ff <= PITCH_RST;
    end else if (wrStb && wbReq.sel[0]) begin
      if (idx == IDX_PITCH_LO) begin
        pitch_ff[7:0] <= wbReq.dat[7:0];
      end else if (idx == IDX_PITCH_HI) begin
        // Only bits 9 and 8 exist; the rest of the byte is dropped
        pitch_ff[PITCH_HI_MSB:8] <= wbReq.dat[1:0];
      end
    end
  end

  // Frame geometry for the walker; the host must size lines to the pitch it chose
  // Both counts take the two low byte lanes, as they are wider than a byte
  // A zero in either count makes the walker ignore the go request
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // An empty frame until software sizes one
      words_ff <= CNT_RST;
      lines_ff <= CNT_RST;
    end else if (wrStb) begin
      if (idx == IDX_FETCH_WORDS) begin
        // Words fetched per display line
        if (wbReq.sel[0]) begin
          words_ff[7:0] <= wbReq.dat[7:0];
        end
        if (wbReq.sel[1]) begin
          words_ff[CNT_W-1:8] <= wbReq.dat[CNT_W-1:8];
        end
      end else if (idx == IDX_FETCH_LINES) begin
        // Display lines per frame
        if (wbReq.sel[0]) begin
          lines_ff[7:0] <= wbReq.dat[7:0];
        end
        if (wbReq.sel[1]) begin
          lines_ff[CNT_W-1:8] <= wbReq.dat[CNT_W-1:8];
        end
      end
    end
  end

  // Start pulse; a request while a frame runs is dropped so the frame is not torn
  // The drop is silent: software polls the busy status before it asks again
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // No frame pending out of reset
      go_ff <= 1'b0;
    end else begin
      // High for one cycle per accepted request
      go_ff <= wrLane0(wrStb, idx, IDX_FETCH_CTRL, wbReq.sel[0]) &&
               wbReq.dat[CTRL_GO_BIT] && !busy;
    end
  end

  // Read mux; unmapped indexes and unused bits read as zero
  // The go bit is write only, so its index falls through to the zero default
  // The address readback is live; software sees it move while a frame runs
  always_comb begin
    nxt_rdData = RDATA_ZERO;
    unique case (idx)
      IDX_EFFECTS: nxt_rdData[7:0] = effects_ff;
      IDX_START_LO: nxt_rdData[7:0] = start_ff[7:0];
      IDX_START_MID: nxt_rdData[7:0] = start_ff[15:8];
      IDX_START_HI: nxt_rdData[0] = start_ff[START_HI_BIT];
      IDX_PITCH_LO: nxt_rdData[7:0] = pitch_ff[7:0];
      IDX_PITCH_HI: nxt_rdData[1:0] = pitch_ff[PITCH_HI_MSB:8];
      IDX_FETCH_WORDS: nxt_rdData[CNT_W-1:0] = words_ff;
      IDX_FETCH_LINES: nxt_rdData[CNT_W-1:0] = lines_ff;
      IDX_FETCH_STATUS: nxt_rdData[STAT_BUSY_BIT] = busy;
      IDX_FETCH_ADDR: nxt_rdData[START_W-1:0] = fetchOut.addr;
      default: nxt_rdData = RDATA_ZERO;
    endcase
  end

  // Bus answer: ack one cycle after the strobe, dropped the next cycle
  // The drop is forced by the ~ack term in the strobes, so a master that holds stb
  // after ack gets a second access on the cycle after the ack; read data is zero whenever ack is low
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // Idle bus answer
      wbRsp <= '0;
    end else begin
      // Every taken access is answered, mapped or not
      wbRsp.ack <= wrStb | rdStb;
      wbRsp.dat <= rdStb ? nxt_rdData : RDATA_ZERO;
    end
  end

  // Registered copy of the live configuration for the display pipeline
  // Registering here keeps every output on a flip-flop and gives the walker a clean
  // copy to latch; the cost is one cycle of delay after each byte write
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // Start address zero is the first dword of the buffer
      cfgOut <= '0;
    end else begin
      // Rotation field decoded into its select code
      cfgOut.rot <= rfac_rot_type'(effects_ff[ROT_MSB:ROT_LSB]);
      cfgOut.start <= start_ff;
      cfgOut.pitch <= pitch_ff;
      cfgOut.effects <= effects_ff;
    end
  end

  // Walker reads the registered configuration, one cycle behind the registers
  // It latches rotation, start, pitch and counts at frame start and keeps them to the end
  rfac_fetch_gen u_fetch (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .goPulse(go_ff),
    .cfg(cfgOut),
    .wordsPerLine(words_ff),
    .lineCount(lines_ff),
    .fetchReady(fetchReady),
    .fetch(fetchOut),
    .busy(busy)
  );

endmodule // rfac_top

//--- tb/rfac_host.sv
// Host model: Wishbone master plus start address and line pitch arithmetic
`timescale 1ns/1ps
module rfac_host (
  input wire logic clk_sys,
  output rfac_pkg::rfac_wb_req_type wbReq,
  input wire rfac_pkg::rfac_wb_rsp_type wbRsp
);
  import rfac_pkg::*;
  // Idle bus from time zero
  initial wbReq = '0;
  // One classic cycle; the request holds until ack is sampled, then falls for a cycle
  task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd,
    output logic [31:0] rd);
    @(posedge clk_sys);
    wbReq <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'hF, {24'h000000, wd}};
    do @(posedge clk_sys); while (wbRsp.ack !== 1'b1);
    rd = wbRsp.dat;
    wbReq <= '0;
  endtask
  // Start dword per rotation; integer division drops every fraction
  function automatic int start_of(input rfac_rot_type r, input int ba, w, h, bpp);
    case (r)
      ROT_0: return ba / 4;
      ROT_90: return (ba + h * bpp / 8) / 4 - 1;
      ROT_180: return (ba + w * h * bpp / 8) / 4 - 1;
      default: return (ba + (w - 1) * h * bpp / 8) / 4;
    endcase
  endfunction
  // Dwords per line rounded up; a padded line gives the wider virtual image
  function automatic int pitch_of(input int w, bpp);
    return (w * bpp + 31) / 32;
  endfunction
endmodule // rfac_host

//--- tb/rfac_top_props.sv
// Checker: bus, configuration and fetch relations at the top ports
`timescale 1ns/1ps
module rfac_top_props (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire rfac_pkg::rfac_wb_req_type wbReq,
  input wire rfac_pkg::rfac_wb_rsp_type wbRsp,
  input wire rfac_pkg::rfac_cfg_type cfgOut,
  input wire logic fetchReady,
  input wire rfac_pkg::rfac_fetch_type fetchOut
);
  import rfac_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Request taken, and a byte write with lane 0 on
  wire logic take = wbReq.cyc && wbReq.stb && !wbRsp.ack;
  wire logic wr8 = take && wbReq.we && wbReq.sel[0];
  wire logic [7:0] idx = wbReq.adr[ADR_IDX_MSB:ADR_IDX_LSB];
  // Fetch accepted by memory
  wire logic step = fetchOut.valid && fetchReady;
  property p_ack; take |=> wbRsp.ack ##1 !wbRsp.ack; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_rot; wr8 && idx == IDX_EFFECTS |-> ##2 cfgOut.rot == $past(wbReq.dat[1:0], 2);
  endproperty
  a_rot: assert property (p_rot) else $error("rotation select wrong");
  property p_startLo;
    wr8 && idx == IDX_START_LO |-> ##2 cfgOut.start[7:0] == $past(wbReq.dat[7:0], 2);
  endproperty
  a_startLo: assert property (p_startLo) else $error("start low byte wrong");
  property p_startHi;
    wr8 && idx == IDX_START_HI |-> ##2 cfgOut.start[16] == $past(wbReq.dat[0], 2);
  endproperty
  a_startHi: assert property (p_startHi) else $error("start bit 16 wrong");
  property p_pitchHi;
    wr8 && idx == IDX_PITCH_HI |-> ##2 cfgOut.pitch[9:8] == $past(wbReq.dat[1:0], 2);
  endproperty
  a_pitchHi: assert property (p_pitchHi) else $error("pitch high bits wrong");
  property p_rst; $fell(sys_rst) |-> cfgOut == '0 && !fetchOut.valid; endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  property p_hold; fetchOut.valid && !fetchReady |=> $stable(fetchOut); endproperty
  a_hold: assert property (p_hold) else $error("fetch changed while stalled");
  property p_row0; step && !fetchOut.lineEnd && cfgOut.rot == ROT_0
    |=> fetchOut.valid && fetchOut.addr == $past(fetchOut.addr) + 17'h00001; endproperty
  a_row0: assert property (p_row0) else $error("unrotated step not one dword");
  property p_done; step && fetchOut.frameEnd |=> !fetchOut.valid; endproperty
  a_done: assert property (p_done) else $error("fetch ran past frame end");
  c_rot270: cover property (wr8 && idx == IDX_EFFECTS && wbReq.dat[1:0] == 2'b11);
  c_stall: cover property (fetchOut.valid && !fetchReady);
  c_frame: cover property (step && fetchOut.frameEnd);
endmodule // rfac_top_props
bind rfac_top rfac_top_props u_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .wbReq(wbReq),
  .wbRsp(wbRsp), .cfgOut(cfgOut), .fetchReady(fetchReady), .fetchOut(fetchOut));

//--- tb/rfac_top_tb.sv
// Testbench: register, rotation and fetch walk scenarios of the rotation block
`timescale 1ns/1ps
module rfac_top_tb;
  import rfac_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic fetchReady = 1'b0;
  rfac_wb_req_type wbReq;
  rfac_wb_rsp_type wbRsp;
  rfac_cfg_type cfgOut;
  rfac_fetch_type fetchOut;
  int failCount = 0;
  int samplesChecked = 0;
  logic [31:0] rd;
  rfac_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .wbReq(wbReq), .wbRsp(wbRsp),
    .cfgOut(cfgOut), .fetchReady(fetchReady), .fetchOut(fetchOut));
  rfac_host host (.clk_sys(clk_sys), .wbReq(wbReq), .wbRsp(wbRsp));
  // 100 MHz clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // Shared compare, case equality so unknowns never match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write, then step off the edge so config outputs have settled
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    host.bus(1'b1, i, d, rd);
    #1;
  endtask
  task automatic t_reset();
    chk(cfgOut.start, 32'h0);
    host.bus(1'b0, IDX_START_LO, 8'h00, rd);
    chk(rd, 32'h0);
    host.bus(1'b0, 8'h7F, 8'h00, rd);
    chk(rd, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_rot();
    for (int r = 3; r >= 0; r--) begin
      wr(IDX_EFFECTS, 8'(r));
      chk(cfgOut.rot, r);
      chk(cfgOut.effects, r);
      host.bus(1'b0, IDX_EFFECTS, 8'h00, rd);
      chk(rd, r);
    end
    $display("t_rot done");
  endtask
  task automatic t_start();
    int s;
    s = host.start_of(ROT_270, 0, 320, 240, 4);
    wr(IDX_START_LO, s[7:0]);
    wr(IDX_START_MID, s[15:8]);
    wr(IDX_START_HI, 8'hFE);
    chk(cfgOut.start, 32'h02562);
    wr(IDX_START_HI, 8'hFF);
    chk(cfgOut.start, 32'h12562);
    host.bus(1'b0, IDX_START_HI, 8'h00, rd);
    chk(rd, 32'h1);
    chk(host.start_of(ROT_0, 0, 320, 240, 4), 32'h0);
    chk(host.start_of(ROT_90, 0, 320, 240, 4), 32'h1D);
    chk(host.start_of(ROT_180, 0, 320, 240, 4), 32'h257F);
    chk(host.pitch_of(100, 4), 32'hD);
    $display("t_start done");
  endtask
  task automatic t_pitch();
    wr(IDX_PITCH_LO, 8'(host.pitch_of(240, 4)));
    wr(IDX_PITCH_HI, 8'hFF);
    chk(cfgOut.pitch, 32'h31E);
    host.bus(1'b0, IDX_PITCH_HI, 8'h00, rd);
    chk(rd, 32'h3);
    $display("t_pitch done");
  endtask
  // Start 0x100, pitch 8, two words by two lines, memory stalling every other cycle
  task automatic t_fetch(input rfac_rot_type r);
    logic [7:0] ia [9];
    logic [7:0] da [9];
    logic [16:0] e;
    int n;
    int k;
    int j;
    ia = '{IDX_EFFECTS, IDX_START_LO, IDX_START_MID, IDX_START_HI, IDX_PITCH_LO,
      IDX_PITCH_HI, IDX_FETCH_WORDS, IDX_FETCH_LINES, IDX_FETCH_CTRL};
    da = '{8'(r), 8'h00, 8'h01, 8'h00, 8'h08, 8'h00, 8'h02, 8'h02, 8'h01};
    for (int i = 0; i < 9; i++) begin
      wr(ia[i], da[i]);
    end
    n = 0;
    for (int c = 0; c < 60 && n < 4; c++) begin
      @(posedge clk_sys);
      if (fetchOut.valid === 1'b1 && fetchReady === 1'b1) begin
        k = n / 2;
        j = n % 2;
        case (r)
          ROT_0: e = 17'(256 + k * 8 + j);
          ROT_90: e = 17'(256 + j * 8 - k);
          ROT_180: e = 17'(256 - k * 8 - j);
          default: e = 17'(256 - j * 8 + k);
        endcase
        chk(fetchOut.addr, e);
        chk(fetchOut.lineEnd, j);
        chk(fetchOut.frameEnd, n == 3);
        n++;
      end
      fetchReady <= ~fetchReady;
    end
    chk(n, 4);
    $display("t_fetch rotation %0d done", r);
  endtask
  // Stalled frame: status and address readback, refused go, mid-frame write, zero frame
  task automatic t_busy();
    int n;
    n = 0;
    @(posedge clk_sys);
    fetchReady <= 1'b0;
    wr(IDX_EFFECTS, 8'h00);
    wr(IDX_FETCH_CTRL, 8'h01);
    host.bus(1'b0, IDX_FETCH_STATUS, 8'h00, rd);
    chk(rd, 32'h1);
    host.bus(1'b0, IDX_FETCH_ADDR, 8'h00, rd);
    chk(rd, 32'h100);
    wr(IDX_START_LO, 8'h40);
    wr(IDX_FETCH_CTRL, 8'h01);
    @(posedge clk_sys);
    fetchReady <= 1'b1;
    for (int c = 0; c < 12; c++) begin
      @(posedge clk_sys);
      if (fetchOut.valid === 1'b1 && fetchReady === 1'b1) begin
        chk(fetchOut.addr, 17'(256 + (n / 2) * 8 + n % 2));
        n++;
      end
    end
    chk(n, 4);
    fetchReady <= 1'b0;
    wr(IDX_FETCH_WORDS, 8'h00);
    wr(IDX_FETCH_CTRL, 8'h01);
    host.bus(1'b0, IDX_FETCH_STATUS, 8'h00, rd);
    chk(rd, 32'h0);
    chk(fetchOut.valid, 1'b0);
    $display("t_busy done");
  endtask
  task automatic wrapUp();
    $display("Checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog far beyond the expected few hundred cycles
  initial begin
    #200000;
    failCount++;
    wrapUp();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_rot();
    t_start();
    t_pitch();
    for (int r = 0; r < 4; r++) begin
      t_fetch(rfac_rot_type'(r));
    end
    t_busy();
    wrapUp();
  end
endmodule // rfac_top_tb
